// file: logic/pfc_chop_gen.sv
// Purpose: Chop clock generator on the prescaled PWM tick
// Assumes: tick is a one-cycle pulse of the prescaled clock
// Notes:   Half period is 8 ticks times divider plus one
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.svh"
module pfc_chop_gen
  import pfc_pkg::*;
#(
  parameter int DIV_W = 7
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             enable,
  input  wire logic             tick,
  input  wire logic [DIV_W-1:0] divider,
  output logic                  chopOut
);

  localparam int CNT_W = DIV_W + 4;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] halfLen;
  wire              halfDone;

  // Divider plus one, times 8 steps per half period
  assign halfLen  = CNT_W'((32'(divider) + 32'd1) * `PFC_CHOP_HALF_MUL);
  assign halfDone = (count >= halfLen - CNT_W'(1));

  always_ff @(posedge mclk) begin
    if (srst || !enable) begin
      count   <= '0;
      chopOut <= 1'b0;
    end else if (tick) begin
      if (halfDone) begin
        count   <= '0;
        chopOut <= ~chopOut;
      end else begin
        count <= count + CNT_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

// file: logic/pfc_ctrl.sv
// Purpose: Special-event compare, chop clock and fault/limit control
// Assumes: Classic Wishbone slave, 32-bit data, fault pins asynchronous
// Notes:   One fault/limit control register per PWM generator
//
// Operation
// - Compare count is 13 bits, bits 15:3
// - Compare step 1.04 ns, resolution 8.32 ns
// - Bit 15 turns chop generator on
// - Chop divider bits 9:3, bits 14:10 and 2:0 read zero
// - Chop period 16.64 times divider plus one
// - Chop generator runs from the prescaled clock
// - Independent mode maps limit high, fault low
// - Normal mode drives both outputs per event
// - Limit source codes pick faults, comparators
// - Limit polarity one means active low
// - Limit mode bit enables limit action
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.svh"
module pfc_ctrl
  import pfc_pkg::*;
#(
  parameter int NUM_GEN = 5
) (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic [31:0]          wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_we_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      wb_err_o,
  input  wire logic                 pwmModuleEnable,
  input  wire logic                 prescaleTick,
  input  wire logic [11:0]          faultPin,
  input  wire logic [3:0]           cmpIn,
  output logic [12:0]               secondaryEventCompareValue,
  output logic                      chopClock,
  output logic [NUM_GEN-1:0]        pwmHighOvrEn,
  output logic [NUM_GEN-1:0]        pwmHighOvr,
  output logic [NUM_GEN-1:0]        pwmLowOvrEn,
  output logic [NUM_GEN-1:0]        pwmLowOvr
);

  // ----------------------------------------------------------------
  // Timing figures
  // ----------------------------------------------------------------
  // Compare LSB equals 1.04 ns; 8 steps make the 8.32 ns resolution
  localparam int CMP_STEPS = `PFC_RES_PS / `PFC_LSB_PS;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [15:0] syncA;
  logic [15:0] syncB;

  always_ff @(posedge mclk) begin
    syncA <= {cmpIn, faultPin};
    syncB <= syncA;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [12:0]  secCmp;
  logic         chopEnable;
  logic [6:0]   chopDivider;
  pfc_fcl_t     fclReg [NUM_GEN];
  pfc_ovr_t     ovrReg [NUM_GEN];
  logic [NUM_GEN-1:0] limitStat;
  logic [NUM_GEN-1:0] faultStat;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire [7:0]  off      = wb_adr_i[7:0];
  wire        hitSec   = (off == `PFC_OFF_SEC_EVENT);
  wire        hitChop  = (off == `PFC_OFF_CHOP);
  wire        hitStat  = (off == `PFC_OFF_STATUS);
  wire [7:0]  fclRel   = off - `PFC_OFF_FCL_BASE;
  wire [7:0]  ovrRel   = off - `PFC_OFF_OVR_DATA;
  wire        hitFcl   = (off >= `PFC_OFF_FCL_BASE) &&
                         (off < `PFC_OFF_OVR_DATA) &&
                         (fclRel[1:0] == 2'b00) &&
                         (32'(fclRel[7:2]) < NUM_GEN);
  wire        hitOvr   = (off >= `PFC_OFF_OVR_DATA) &&
                         (off < `PFC_OFF_STATUS) &&
                         (ovrRel[1:0] == 2'b00) &&
                         (32'(ovrRel[7:2]) < NUM_GEN);
  wire [2:0]  fclIdx   = fclRel[4:2];
  wire [2:0]  ovrIdx   = ovrRel[4:2];
  wire        upper32  = (wb_adr_i[31:8] != 24'h000000);
  wire        mapped   = ~upper32 & (hitSec | hitChop | hitStat |
                                     hitFcl | hitOvr);
  wire        wrLo     = req & mapped & wb_we_i & wb_sel_i[0];
  wire        wrHi     = req & mapped & wb_we_i & wb_sel_i[1];
  wire [15:0] wd       = wb_dat_i[15:0];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [15:0] rdVal;

  always_comb begin
    rdVal = 16'h0000;
    if (hitSec) begin
      rdVal = {secCmp, 3'b000};
    end else if (hitChop) begin
      rdVal = {chopEnable, 5'b00000, chopDivider, 3'b000};
    end else if (hitFcl) begin
      rdVal = 16'(fclReg[fclIdx]);
    end else if (hitOvr) begin
      rdVal = {12'h000, ovrReg[ovrIdx]};
    end else if (hitStat) begin
      rdVal = {3'b000, NUM_GEN'(faultStat), 3'b000, NUM_GEN'(limitStat)};
    end
  end

  // ----------------------------------------------------------------
  // Bus answer, registered, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
      wb_dat_o <= (req & mapped & ~wb_we_i) ? {16'h0000, rdVal}
                                            : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      secCmp      <= 13'h0000;
      chopEnable  <= 1'b0;
      chopDivider <= 7'h00;
    end else begin
      if (wrLo && hitSec) secCmp[4:0] <= wd[7:3];
      if (wrHi && hitSec) secCmp[12:5] <= wd[15:8];
      if (wrLo && hitChop) chopDivider[4:0] <= wd[7:3];
      if (wrHi && hitChop) begin
        chopDivider[6:5] <= wd[9:8];
        chopEnable       <= wd[`PFC_CHOP_EN_BIT];
      end
    end
  end

  // Polarity is taken as written; software keeps it steady while
  // the module runs, otherwise a glitch override may result
  for (genvar g = 0; g < NUM_GEN; g++) begin : genFcl
    always_ff @(posedge mclk) begin
      if (srst) begin
        fclReg[g] <= pfc_fcl_t'(`PFC_RST_REG16);
        ovrReg[g] <= pfc_ovr_t'(4'h0);
      end else begin
        if (wrLo && hitFcl && 32'(fclIdx) == g)
          fclReg[g][7:0] <= wd[7:0];
        if (wrHi && hitFcl && 32'(fclIdx) == g)
          fclReg[g][15:8] <= wd[15:8];
        if (wrLo && hitOvr && 32'(ovrIdx) == g)
          ovrReg[g] <= pfc_ovr_t'(wd[3:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Chop clock
  // ----------------------------------------------------------------
  logic chopRaw;

  pfc_chop_gen #(
    .DIV_W   (7)
  ) uChop (
    .mclk    (mclk),
    .srst    (srst),
    .enable  (chopEnable & pwmModuleEnable),
    .tick    (prescaleTick),
    .divider (chopDivider),
    .chopOut (chopRaw)
  );

  // ----------------------------------------------------------------
  // Fault mapping per generator
  // ----------------------------------------------------------------
  logic [NUM_GEN-1:0] hiEn;
  logic [NUM_GEN-1:0] hiVal;
  logic [NUM_GEN-1:0] loEn;
  logic [NUM_GEN-1:0] loVal;
  logic [NUM_GEN-1:0] limAct;
  logic [NUM_GEN-1:0] fltAct;

  for (genvar g = 0; g < NUM_GEN; g++) begin : genMap
    pfc_fault_map uMap (
      .ctrl      (fclReg[g]),
      .ovr       (ovrReg[g]),
      .faultIn   (syncB[11:0]),
      .cmpIn     (syncB[15:12]),
      .limitAct  (limAct[g]),
      .faultAct  (fltAct[g]),
      .ovrHighEn (hiEn[g]),
      .ovrHigh   (hiVal[g]),
      .ovrLowEn  (loEn[g]),
      .ovrLow    (loVal[g])
    );
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      secondaryEventCompareValue <= 13'h0000;
      chopClock    <= 1'b0;
      pwmHighOvrEn <= '0;
      pwmHighOvr   <= '0;
      pwmLowOvrEn  <= '0;
      pwmLowOvr    <= '0;
      limitStat    <= '0;
      faultStat    <= '0;
    end else begin
      secondaryEventCompareValue <= secCmp;
      chopClock    <= chopRaw;
      pwmHighOvrEn <= hiEn & {NUM_GEN{pwmModuleEnable}};
      pwmHighOvr   <= hiVal;
      pwmLowOvrEn  <= loEn & {NUM_GEN{pwmModuleEnable}};
      pwmLowOvr    <= loVal;
      limitStat    <= limAct;
      faultStat    <= fltAct;
    end
  end

endmodule
`default_nettype wire

// file: logic/pfc_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit Wishbone words, 16-bit registers in low bits
// Notes:   Definitions only
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PFC_OFF_SEC_EVENT   8'h00
`define PFC_OFF_CHOP        8'h04
`define PFC_OFF_FCL_BASE    8'h08
`define PFC_OFF_OVR_DATA    8'h1C
`define PFC_OFF_STATUS      8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PFC_SEC_CMP_HI      15
`define PFC_SEC_CMP_LO      3
`define PFC_CHOP_EN_BIT     15
`define PFC_CHOP_DIV_HI     9
`define PFC_CHOP_DIV_LO     3
`define PFC_IFM_BIT         15
`define PFC_LSRC_HI         14
`define PFC_LSRC_LO         10
`define PFC_LPOL_BIT        9
`define PFC_LMOD_BIT        8
`define PFC_FSRC_HI         7
`define PFC_FSRC_LO         3
`define PFC_FPOL_BIT        2
`define PFC_FMOD_HI         1
`define PFC_FMOD_LO         0

// ----------------------------------------------------------------
// Reset values and source codes
// ----------------------------------------------------------------
`define PFC_RST_REG16       16'h0000
`define PFC_SRC_FAULT_FIRST 5'h01
`define PFC_SRC_FAULT_LAST  5'h0C
`define PFC_SRC_CMP_LAST    5'h10

// ----------------------------------------------------------------
// Timing: compare step in ps, chop divider step count
// ----------------------------------------------------------------
`define PFC_LSB_PS          1040
`define PFC_RES_PS          8320
`define PFC_CHOP_HALF_MUL   8

`endif

// file: logic/pfc_fault_map.sv
// Purpose: Per-generator fault and current-limit override mapping
// Assumes: Source vectors already synchronised
// Notes:   Reserved source codes select no input
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.svh"
module pfc_fault_map
  import pfc_pkg::*;
(
  input  wire pfc_fcl_t    ctrl,
  input  wire pfc_ovr_t    ovr,
  input  wire logic [11:0] faultIn,
  input  wire logic [3:0]  cmpIn,
  output logic             limitAct,
  output logic             faultAct,
  output logic             ovrHighEn,
  output logic             ovrHigh,
  output logic             ovrLowEn,
  output logic             ovrLow
);

  function automatic logic pickSrc(input logic [4:0] code,
                                   input logic [11:0] flt,
                                   input logic [3:0] cmp);
    logic r;
    r = 1'b0;
    if (code >= `PFC_SRC_FAULT_FIRST && code <= `PFC_SRC_FAULT_LAST)
      r = flt[4'(code - 5'h01)];
    else if (code > `PFC_SRC_FAULT_LAST && code <= `PFC_SRC_CMP_LAST)
      r = cmp[2'(code - 5'h0D)];
    return r;
  endfunction

  wire limitRaw = pickSrc(ctrl.limitSrc, faultIn, cmpIn);
  wire faultRaw = pickSrc(ctrl.faultSrc, faultIn, cmpIn);
  wire limitLvl = limitRaw ^ ctrl.limitPol;
  wire faultLvl = faultRaw ^ ctrl.faultPol;

  assign limitAct = limitLvl & ctrl.limitEn;
  assign faultAct = faultLvl & (ctrl.faultMode != 2'b11);

  // Fault outranks current limit in normal mode
  wire normHighEn = faultAct | limitAct;
  wire normHigh   = faultAct ? ovr.faultData[1] : ovr.limitData[1];
  wire normLow    = faultAct ? ovr.faultData[0] : ovr.limitData[0];

  assign ovrHighEn = ctrl.indepMode ? limitAct : normHighEn;
  assign ovrHigh   = ctrl.indepMode ? ovr.faultData[1] : normHigh;
  assign ovrLowEn  = ctrl.indepMode ? faultAct : normHighEn;
  assign ovrLow    = ctrl.indepMode ? ovr.faultData[0] : normLow;

endmodule
`default_nettype wire

// file: logic/pfc_pkg.sv
// Purpose: Shared types of the fault, chop and event control block
// Assumes: Included defines header
// Notes:   Types only
package pfc_pkg;

  typedef struct packed {
    logic       indepMode;
    logic [4:0] limitSrc;
    logic       limitPol;
    logic       limitEn;
    logic [4:0] faultSrc;
    logic       faultPol;
    logic [1:0] faultMode;
  } pfc_fcl_t;

  typedef struct packed {
    logic [1:0] faultData;
    logic [1:0] limitData;
  } pfc_ovr_t;

  typedef enum logic [1:0] {
    PFC_OVR_NONE  = 2'b00,
    PFC_OVR_LIMIT = 2'b01,
    PFC_OVR_FAULT = 2'b10
  } pfc_ovr_sel_t;

endpackage

// file: tb/pfc_ctrl_props.sv
// Purpose: Bus and output checks of the control block
// Assumes: Sees the top-level ports only
// Notes:   Bound into every pfc_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module pfc_ctrl_props
  import pfc_pkg::*;
#(
  parameter int NUM_GEN = 5
) (
  input wire logic               mclk,
  input wire logic               srst,
  input wire logic [31:0]        wb_adr_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic [3:0]         wb_sel_i,
  input wire logic               wb_we_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic               wb_err_o,
  input wire logic               pwmModuleEnable,
  input wire logic               prescaleTick,
  input wire logic [11:0]        faultPin,
  input wire logic [3:0]         cmpIn,
  input wire logic [12:0]        secondaryEventCompareValue,
  input wire logic               chopClock,
  input wire logic [NUM_GEN-1:0] pwmHighOvrEn,
  input wire logic [NUM_GEN-1:0] pwmHighOvr,
  input wire logic [NUM_GEN-1:0] pwmLowOvrEn,
  input wire logic [NUM_GEN-1:0] pwmLowOvr
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic [12:0] secExp;
  wire         secWr = wb_ack_o && wb_we_i && wb_adr_i == 32'h0 &&
                       (&wb_sel_i[1:0]);
  wire         rdAck = wb_ack_o && !wb_we_i;
  // Captured at the write so the output copy may lag one edge
  always_ff @(posedge mclk) begin
    if (secWr) begin
      secExp <= wb_dat_i[15:3];
    end
  end
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |->
    $past(wb_cyc_i && wb_stb_i)) else $error("ack without a request");
  AST_ERR_UNMAP: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
    !wb_err_o && wb_adr_i[31:8] != 24'h0 |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  AST_SEC_READ: assert property (rdAck && wb_adr_i == 32'h0 |->
    wb_dat_o[2:0] == 3'h0 && wb_dat_o[31:16] == 16'h0)
    else $error("compare low bits not zero");
  AST_CHOP_READ: assert property (rdAck && wb_adr_i == 32'h4 |->
    wb_dat_o[14:10] == 5'h0 && wb_dat_o[2:0] == 3'h0)
    else $error("chop unused bits not zero");
  AST_SEC_OUT: assert property (secWr |=> ##[0:1]
    secondaryEventCompareValue == secExp) else $error("compare copy stale");
  AST_OVR_GATE: assert property (!pwmModuleEnable [*3] |->
    pwmHighOvrEn == '0 && pwmLowOvrEn == '0)
    else $error("override while module off");
  AST_CHOP_IDLE: assert property (!pwmModuleEnable [*3] |=>
    $stable(chopClock)) else $error("chop moves while module off");
  COV_SEC: cover property (secWr);
  COV_ERR: cover property (wb_err_o);
  COV_OVR: cover property (pwmHighOvrEn[0] && pwmLowOvrEn[0]);
endmodule
bind pfc_ctrl pfc_ctrl_props #(.NUM_GEN(NUM_GEN)) u_props (.*);
`default_nettype wire

// file: tb/pfc_fault_src.sv
// Purpose: Fault pins and comparators seen from outside
// Assumes: Levels requested by the bench
// Notes:   Changes just after the edge, like a real pin
`timescale 1ns/1ps
`default_nettype none
module pfc_fault_src (
  input  wire logic        mclk,
  input  wire logic [11:0] faultReq,
  input  wire logic [3:0]  cmpReq,
  output logic [11:0]      faultPin,
  output logic [3:0]       cmpIn
);
  // ------------------------------------------------------------
  // Sources: fault 1..12 then comparator 1..4
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    faultPin <= faultReq;
    cmpIn    <= cmpReq;
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Purpose: Register, chop and override tests
// Assumes: Classic Wishbone, generator 0 observed
// Notes:   Polarity rewritten only with the module off
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pfc_pkg::*;
  logic        mclk, srst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o;
  logic        pwmModuleEnable, prescaleTick, tickSlow, chopClock;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i, cmpReq, cmpIn;
  logic [11:0] faultReq, faultPin;
  logic [12:0] secondaryEventCompareValue;
  logic [4:0]  pwmHighOvrEn, pwmHighOvr, pwmLowOvrEn, pwmLowOvr;
  int          failures, tests_run, i, c;
  logic [31:0] q;
  logic        e;
  // ------------------------------------------------------------
  // Plumbing
  // ------------------------------------------------------------
  pfc_ctrl dut_u (.*);
  pfc_fault_src src_u (.*);
  always #2 mclk = ~mclk;
  always @(posedge mclk) prescaleTick <= tickSlow ? ~prescaleTick : 1'b1;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [15:0] d);
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hF};
    wb_adr_i <= a;
    wb_dat_i <= {16'h0, d};
    // No local limit: only the watchdog ends a hung wait
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o;
    e = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] x);
    xfer(a, 1'b0, 16'h0);
    chk(q, {16'h0, x});
  endtask
  // Half period in cycles, zero if the clock never moves
  task automatic per();
    logic v;
    int   n;
    c = 0;
    n = 0;
    v = chopClock;
    while (chopClock === v && n < 200) begin
      @(posedge mclk);
      n++;
    end
    v = chopClock;
    while (n < 200 && chopClock === v && c < 200) begin
      @(posedge mclk);
      c++;
    end
  endtask
  // Masked so a value under a low enable is not judged
  task automatic ovr(input logic [3:0] x);
    repeat (5) @(posedge mclk);
    chk({pwmHighOvrEn[0], pwmHighOvr[0] & pwmHighOvrEn[0],
         pwmLowOvrEn[0], pwmLowOvr[0] & pwmLowOvrEn[0]}, x);
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    end_of_test();
  end
  initial begin
    {mclk, srst, wb_we_i, wb_cyc_i, wb_stb_i, tickSlow} = 6'b010000;
    {wb_adr_i, wb_dat_i, wb_sel_i, faultReq, cmpReq} = '0;
    {pwmModuleEnable, prescaleTick} = 2'b00;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    for (i = 0; i < 9; i++) rd(32'(i * 4), 16'h0);
    xfer(32'h0, 1'b1, 16'hFFFF);
    rd(32'h0, 16'hFFF8);
    chk(secondaryEventCompareValue, 13'h1FFF);
    xfer(32'h4, 1'b1, 16'hFFFF);
    rd(32'h4, 16'h83F8);
    xfer(32'h100, 1'b1, 16'h0);
    chk(e, 1'b1);
    rd(32'h0, 16'hFFF8);
    $display("test registers done");
    pwmModuleEnable <= 1'b1;
    xfer(32'h4, 1'b1, 16'h8008);
    per();
    chk(c, 16);
    tickSlow <= 1'b1;
    per();
    chk(c, 32);
    xfer(32'h4, 1'b1, 16'h0008);
    per();
    chk(c, 0);
    $display("test chop done");
    xfer(32'h1C, 1'b1, 16'h0009);
    xfer(32'h8, 1'b1, 16'h0568);
    faultReq[0] <= 1'b1;
    ovr(4'hB);
    cmpReq[0] <= 1'b1;
    ovr(4'hE);
    rd(32'h20, 16'h0101);
    xfer(32'h8, 1'b1, 16'h8568);
    ovr(4'hE);
    cmpReq[0] <= 1'b0;
    ovr(4'hC);
    {faultReq[0], cmpReq[0]} <= 2'b01;
    ovr(4'h2);
    xfer(32'h8, 1'b1, 16'h056B);
    ovr(4'h0);
    {faultReq[0], cmpReq[0]} <= 2'b10;
    xfer(32'h8, 1'b1, 16'h0468);
    ovr(4'h0);
    {faultReq[0], pwmModuleEnable} <= 2'b00;
    xfer(32'h8, 1'b1, 16'h0768);
    pwmModuleEnable <= 1'b1;
    ovr(4'hB);
    $display("test overrides done");
    for (i = 0; i < 18; i++) begin
      pwmModuleEnable <= 1'b0;
      xfer(32'h8, 1'b1, {1'b0, 5'(i), 10'h10B});
      pwmModuleEnable <= 1'b1;
      {cmpReq, faultReq} <= (i > 0 && i < 17) ? 16'h1 << (i - 1) : 16'hFFFF;
      ovr((i > 0 && i < 17) ? 4'hB : 4'h0);
    end
    $display("test sources done");
    end_of_test();
  end
endmodule
`default_nettype wire
